// file: logic/trlcp_pkg.sv
/*
 * Shared constants and types of the three-channel line codec port:
 * register map, control field layout, line rates, symbol codes and the
 * counts used by the signal and lock supervisors.
 * Assumes every file that uses it names items as trlcp_pkg::name.
 */
`default_nettype none

package trlcp_pkg;

  localparam int NUM_CH = 3;

  // Register map, byte addresses on the APB port.
  localparam logic [11:0] CTRL_BASE   = 12'h000;
  localparam logic [11:0] STATUS_BASE = 12'h010;
  localparam logic [11:0] BLOCK_MASK  = 12'hFF0;

  // Line rate codes held in the control register.
  typedef enum logic [1:0] {
    RATE_DS3  = 2'h0,
    RATE_E3   = 2'h1,
    RATE_STS1 = 2'h2
  } trlcp_rate_t;

  // Per-channel control register, bits 7..0 of the word.
  typedef struct packed {
    logic        tx_off;
    logic        mute_on_los;
    logic        equalizer_on;
    logic        codec_off;
    logic        rx_clock_invert;
    logic        tx_rising_edge;
    trlcp_rate_t rate;
  } trlcp_ctrl_t;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int         CTRL_W     = 8;

  // Status register field positions.
  localparam int STAT_RATE_LSB = 0;
  localparam int STAT_LOS_BIT  = 2;
  localparam int STAT_LOL_BIT  = 3;
  localparam int STAT_OFF_BIT  = 4;
  localparam int STAT_MODE_BIT = 5;

  // Encoder symbols in the substitution delay line.
  typedef enum logic [1:0] {
    SYM_ZERO = 2'h0,
    SYM_MARK = 2'h1,
    SYM_BIP  = 2'h2,
    SYM_VIOL = 2'h3
  } trlcp_sym_t;

  // One received or transmitted bipolar symbol.
  typedef struct packed {
    logic pos;
    logic neg;
  } trlcp_rail_t;

  // Zero runs replaced by a substitution code.
  localparam logic [2:0] B3ZS_RUN = 3'h3;
  localparam logic [2:0] HDB3_RUN = 3'h4;

  // Supervisor counts, in recovered or reference clock cycles.
  localparam int LOS_ZERO_RUN      = 175;
  localparam int LOCK_WINDOW       = 1000;
  localparam int LOCK_TOL_PERMILLE = 5;
  localparam int LOCK_TOL = (LOCK_WINDOW * LOCK_TOL_PERMILLE) / 1000;

  // Inputs synchronised per channel and shared.
  localparam int SYNC_PER_CH = 12;
  localparam int SYNC_SHARED = 3;

endpackage

`default_nettype wire

// file: logic/trlcp_sync.sv
/*
 * Two-stage synchroniser for a bundle of asynchronous levels.
 * Assumes the inputs are levels or clocks slow enough for the sampling
 * clock to see every phase.
 */
`timescale 1ns/1ns
`default_nettype none

module trlcp_sync #(
  parameter int WIDTH = 1
) (
  // Clock, reset and enable
  input  wire  logic             clk_i,
  input  wire  logic             rst_n_i,
  input  wire  logic             ce_i,
  // Data
  input  wire  logic [WIDTH-1:0] async_i,
  output logic       [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_reg;

  // Only the second stage reads the first one.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_reg <= '0;
      sync_o   <= '0;
    end else if (ce_i) begin
      meta_reg <= async_i;
      sync_o   <= meta_reg;
    end
  end

endmodule // trlcp_sync

`default_nettype wire

// file: logic/trlcp_port.sv
/*
 * Digital side of a three-channel DS3/E3/STS-1 line interface: zero
 * substitution encoder and decoder, rail formatting, violation, signal
 * loss and lock loss supervision, and an APB register port for host mode.
 * Assumes every pin input, including the terminal, recovered and
 * reference clocks, is asynchronous to clk_i and far slower than it.
 */
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - Each channel picks E3, DS3 or STS-1 independently of the others.
// - Transmit encodes B3ZS for DS3 and STS-1, HDB3 for E3.
// - Receive decodes, supervises signal and lock, and flags code violations.
// - Encoder and decoder can be disabled, passing rails untouched.
// - Transmit rails sampled on falling clock edge; host may pick rising.
// - Positive rail one gives positive pulse, negative rail one negative.
// - Transmit accepts single-rail data on positive rail or dual-rail data.
// - Build-out pin high disables build-out; hardware mode, DS3/STS-1 only.
// - Transmitter-off pin high floats both line outputs in any mode.
// - Recovered clock is output; receive rails update on its rising edge.
// - Host invert bit moves receive rail updates to the falling edge.
// - Hardware invert pin inverts every recovered clock output.
// - Host mode register reset pin low restores default control values.
// - Receive rails pulse high for each positive or negative line pulse.
// - Enabled decoder replaces substitution codes with zeros.
// - Receive data leaves in single-rail or dual-rail form.
// - Receive data may be muted while signal loss is declared.
// - Equalizer pin turns equalizer on or off; ignored in host mode.
// - Shared format pin high gives single-rail, low dual-rail output.
// - Lock loss when recovered and reference rates differ beyond 0.5%.
// - Violation flag gives one-bit high pulse per detected violation.
// - Mode pin high selects host mode, low hardware pin control.
module trlcp_port #(
  parameter int LOS_RUN   = trlcp_pkg::LOS_ZERO_RUN,
  parameter int LOCK_WIN  = trlcp_pkg::LOCK_WINDOW,
  parameter int LOCK_TOL  = trlcp_pkg::LOCK_TOL
) (
  // Clock, reset and enable
  input  wire  logic                           clk_i,
  input  wire  logic                           reset_n_i,
  input  wire  logic                           ce_i,
  // APB slave
  input  wire  logic                           psel_i,
  input  wire  logic                           penable_i,
  input  wire  logic                           pwrite_i,
  input  wire  logic [11:0]                    paddr_i,
  input  wire  logic [31:0]                    pwdata_i,
  input  wire  logic [3:0]                     pstrb_i,
  output logic                                 pready_o,
  output logic       [31:0]                    prdata_o,
  output logic                                 pslverr_o,
  // Shared mode pins
  input  wire  logic                           host_mode_select_i,
  input  wire  logic                           command_reg_reset_n_i,
  input  wire  logic                           rx_rail_format_select_i,
  // Transmit terminal side, per channel
  input  wire  logic [trlcp_pkg::NUM_CH-1:0]   tx_term_clock_i,
  input  wire  logic [trlcp_pkg::NUM_CH-1:0]   tx_pos_rail_i,
  input  wire  logic [trlcp_pkg::NUM_CH-1:0]   tx_neg_rail_i,
  // Hardware mode control pins, per channel
  input  wire  logic [trlcp_pkg::NUM_CH-1:0]   e3_select_i,
  input  wire  logic [trlcp_pkg::NUM_CH-1:0]   sts1_select_i,
  input  wire  logic [trlcp_pkg::NUM_CH-1:0]   buildout_disable_i,
  input  wire  logic [trlcp_pkg::NUM_CH-1:0]   transmitter_off_i,
  input  wire  logic [trlcp_pkg::NUM_CH-1:0]   equalizer_enable_i,
  // Line side, per channel
  output logic       [trlcp_pkg::NUM_CH-1:0]   line_out_tip_o,
  output logic       [trlcp_pkg::NUM_CH-1:0]   line_out_ring_o,
  output logic       [trlcp_pkg::NUM_CH-1:0]   line_out_oe_n_o,
  input  wire  logic [trlcp_pkg::NUM_CH-1:0]   line_in_tip_i,
  input  wire  logic [trlcp_pkg::NUM_CH-1:0]   line_in_ring_i,
  input  wire  logic [trlcp_pkg::NUM_CH-1:0]   line_clock_i,
  input  wire  logic [trlcp_pkg::NUM_CH-1:0]   lock_reference_clock_i,
  // Analog front end controls, per channel
  output logic       [trlcp_pkg::NUM_CH-1:0]   buildout_on_o,
  output logic       [trlcp_pkg::NUM_CH-1:0]   equalizer_on_o,
  // Receive terminal side, per channel
  output logic       [trlcp_pkg::NUM_CH-1:0]   recovered_clock_out_o,
  output logic       [trlcp_pkg::NUM_CH-1:0]   rx_pos_rail_o,
  output logic       [trlcp_pkg::NUM_CH-1:0]   rx_neg_rail_o,
  output logic       [trlcp_pkg::NUM_CH-1:0]   code_violation_flag_o,
  output logic       [trlcp_pkg::NUM_CH-1:0]   signal_loss_flag_o,
  output logic       [trlcp_pkg::NUM_CH-1:0]   lock_loss_flag_o
);

  localparam int NCH = trlcp_pkg::NUM_CH;
  localparam int PCH = trlcp_pkg::SYNC_PER_CH;
  localparam int SW  = NCH * PCH + trlcp_pkg::SYNC_SHARED;

  logic [1:0]    rst_pipe_reg;
  logic          rst_n;
  logic [SW-1:0] pins_async;
  logic [SW-1:0] pins;
  logic          host;
  logic          command_reg_reset_n_pin;
  logic          single_rail;

  trlcp_pkg::trlcp_ctrl_t ctrl_reg [NCH];
  logic [31:0]            status_word [NCH];

  // Reset leaves through two flip-flops so release is synchronous.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_pipe_reg <= 2'b00;
    end else begin
      rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe_reg[1];

  always_comb begin
    pins_async = '0;
    for (int c = 0; c < NCH; c++) begin
      pins_async[c*PCH +: PCH] = {tx_term_clock_i[c], tx_pos_rail_i[c],
        tx_neg_rail_i[c], line_clock_i[c], line_in_tip_i[c],
        line_in_ring_i[c], lock_reference_clock_i[c], e3_select_i[c],
        sts1_select_i[c], buildout_disable_i[c], transmitter_off_i[c],
        equalizer_enable_i[c]};
    end
    pins_async[SW-1 -: 3] = {host_mode_select_i, command_reg_reset_n_i,
                             rx_rail_format_select_i};
  end

  trlcp_sync #(
    .WIDTH (SW)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .ce_i    (ce_i),
    .async_i (pins_async),
    .sync_o  (pins)
  );

  assign host        = pins[SW-1];
  assign command_reg_reset_n_pin    = pins[SW-2];
  assign single_rail = pins[SW-3];

  // APB: zero wait states, read data captured in the setup cycle.
  logic        rd_sel_ctrl;
  logic        rd_sel_stat;
  logic [1:0]  rd_idx;
  logic        addr_ok;
  logic        wr_take;

  always_comb begin
    rd_idx      = paddr_i[3:2];
    rd_sel_ctrl = (paddr_i & trlcp_pkg::BLOCK_MASK) == trlcp_pkg::CTRL_BASE;
    rd_sel_stat = (paddr_i & trlcp_pkg::BLOCK_MASK) ==
                  trlcp_pkg::STATUS_BASE;
    addr_ok     = (rd_sel_ctrl || rd_sel_stat) && (int'(rd_idx) < NCH);
  end

  assign pready_o = psel_i & penable_i & ce_i;
  assign wr_take  = pready_o & pwrite_i & addr_ok & rd_sel_ctrl & pstrb_i[0];

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else if (ce_i && psel_i && !penable_i) begin
      pslverr_o <= !addr_ok;
      prdata_o  <= 32'h0000_0000;
      if (addr_ok && !pwrite_i) begin
        prdata_o <= rd_sel_ctrl
          ? {24'h00_0000, ctrl_reg[rd_idx]}
          : status_word[rd_idx];
      end
    end
  end

  // The register reset pin only acts in host mode; in hardware mode the
  // same pin is the receive clock invert select.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      for (int c = 0; c < NCH; c++) begin
        ctrl_reg[c] <= trlcp_pkg::CTRL_RESET;
      end
    end else if (ce_i) begin
      if (host && !command_reg_reset_n_pin) begin
        for (int c = 0; c < NCH; c++) begin
          ctrl_reg[c] <= trlcp_pkg::CTRL_RESET;
        end
      end else if (wr_take) begin
        ctrl_reg[rd_idx] <= pwdata_i[trlcp_pkg::CTRL_W-1:0];
      end
    end
  end

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    logic tck, tpos, tneg, rck, line_in_tip, line_in_ring, refck;
    logic e3p, stsp, bodis, txoffp, eqp;
    logic tck_q, rck_q, refck_q;
    logic tx_edge, rx_rise, rx_fall, ref_rise, upd;
    logic [2:0] run_len;
    logic [1:0] last;
    trlcp_pkg::trlcp_ctrl_t cfg;

    assign {tck, tpos, tneg, rck, line_in_tip, line_in_ring, refck, e3p, stsp, bodis,
            txoffp, eqp} = pins[c*PCH +: PCH];

    // Effective configuration: registers in host mode; otherwise rate and equalizer from pins, other fields at reset values.
    always_comb begin
      cfg = trlcp_pkg::CTRL_RESET;
      if (host) begin
        cfg = ctrl_reg[c];
      end else begin
        cfg.rate = e3p  ? trlcp_pkg::RATE_E3 :
                   stsp ? trlcp_pkg::RATE_STS1 : trlcp_pkg::RATE_DS3;
        cfg.equalizer_on = eqp;
      end
    end

    assign run_len = (cfg.rate == trlcp_pkg::RATE_E3)
                     ? trlcp_pkg::HDB3_RUN : trlcp_pkg::B3ZS_RUN;
    assign last    = 2'(run_len - 3'h1);

    always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
        tck_q   <= 1'b0;
        rck_q   <= 1'b0;
        refck_q <= 1'b0;
      end else if (ce_i) begin
        tck_q   <= tck;
        rck_q   <= rck;
        refck_q <= refck;
      end
    end

    assign tx_edge  = cfg.tx_rising_edge ? (tck && !tck_q)
                                         : (!tck && tck_q);
    assign rx_rise  = rck && !rck_q;
    assign rx_fall  = !rck && rck_q;
    assign ref_rise = refck && !refck_q;
    assign upd      = (host && cfg.rx_clock_invert) ? rx_fall
                                                    : rx_rise;

    // Transmit encoder, stepped once per selected terminal clock edge.
    trlcp_pkg::trlcp_sym_t [3:0] enc_sr_reg, enc_sr_next;
    trlcp_pkg::trlcp_sym_t       enc_out;
    logic [2:0] zrun_reg, zrun_next;
    logic       par_reg, par_next;
    logic       pol_reg;
    logic       enc_on;
    logic       tip_reg, ring_reg;

    // A high negative rail means dual-rail data: the codec stands aside.
    assign enc_on  = !cfg.codec_off && !tneg;
    assign enc_out = enc_sr_reg[last];

    always_comb begin
      enc_sr_next    = {enc_sr_reg[2:0], tpos ? trlcp_pkg::SYM_MARK
                                              : trlcp_pkg::SYM_ZERO};
      zrun_next      = tpos ? 3'h0 : 3'(zrun_reg + 3'h1);
      par_next       = par_reg ^ tpos;
      if (!tpos && zrun_reg == 3'(run_len - 3'h1)) begin
        enc_sr_next[0] = trlcp_pkg::SYM_VIOL;
        if (!par_reg) begin
          enc_sr_next[last] = trlcp_pkg::SYM_BIP;
        end
        zrun_next = 3'h0;
        par_next  = 1'b0;
      end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
        enc_sr_reg <= '0;
        zrun_reg   <= 3'h0;
        par_reg    <= 1'b0;
        pol_reg    <= 1'b0;
        tip_reg    <= 1'b0;
        ring_reg   <= 1'b0;
      end else if (ce_i && tx_edge) begin
        if (!enc_on) begin
          tip_reg    <= tpos;
          ring_reg   <= tneg;
          enc_sr_reg <= '0;
          zrun_reg   <= 3'h0;
          par_reg    <= 1'b0;
        end else begin
          enc_sr_reg <= enc_sr_next;
          zrun_reg   <= zrun_next;
          par_reg    <= par_next;
          tip_reg    <= 1'b0;
          ring_reg   <= 1'b0;
          if (enc_out == trlcp_pkg::SYM_VIOL) begin
            tip_reg  <= pol_reg;
            ring_reg <= !pol_reg;
          end else if (enc_out != trlcp_pkg::SYM_ZERO) begin
            pol_reg  <= !pol_reg;
            tip_reg  <= !pol_reg;
            ring_reg <= pol_reg;
          end
        end
      end
    end

    // Floated outputs are also driven low so nothing toggles under them.
    assign line_out_oe_n_o[c] = txoffp || (host && cfg.tx_off);
    assign line_out_tip_o[c]  = tip_reg && !line_out_oe_n_o[c];
    assign line_out_ring_o[c] = ring_reg && !line_out_oe_n_o[c];
    assign buildout_on_o[c]   = !host && !bodis &&
                                (cfg.rate != trlcp_pkg::RATE_E3);
    assign equalizer_on_o[c]  = cfg.equalizer_on;

    // Receive decoder, stepped once per recovered clock rising edge.
    trlcp_pkg::trlcp_rail_t [3:0] dsr_reg, dsr_next;
    trlcp_pkg::trlcp_rail_t       rx_sym, pend_reg;
    logic dpol_reg, dseen_reg, lcv_next, lcv_pend_reg, dec_on, sub_ok;

    assign rx_sym = '{pos: line_in_tip && !line_in_ring, neg: line_in_ring && !line_in_tip};
    assign dec_on = !cfg.codec_off && !tneg;

    always_comb begin
      dsr_next = {dsr_reg[2:0], rx_sym};
      lcv_next = 1'b0;
      sub_ok   = (dsr_reg[0] == '0) &&
                 (run_len == trlcp_pkg::B3ZS_RUN || dsr_reg[1] == '0);
      if ((rx_sym.pos || rx_sym.neg) && dseen_reg &&
          rx_sym.pos == dpol_reg) begin
        if (dec_on && sub_ok) begin
          for (int k = 0; k < 4; k++) begin
            if (k < int'(run_len)) begin
              dsr_next[k] = '0;
            end
          end
        end else begin
          lcv_next = 1'b1;
        end
      end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
        dsr_reg      <= '0;
        pend_reg     <= '0;
        dpol_reg     <= 1'b0;
        dseen_reg    <= 1'b0;
        lcv_pend_reg <= 1'b0;
      end else if (ce_i && rx_rise) begin
        dsr_reg      <= dsr_next;
        pend_reg     <= dsr_reg[last];
        lcv_pend_reg <= lcv_next;
        if (rx_sym.pos || rx_sym.neg) begin
          dpol_reg  <= rx_sym.pos;
          dseen_reg <= 1'b1;
        end
      end
    end

    // Signal loss: a run of received zeros; any pulse clears it.
    logic [15:0] zcnt_reg;
    logic        los_reg;

    always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
        zcnt_reg <= 16'h0000;
        los_reg  <= 1'b0;
      end else if (ce_i && rx_rise) begin
        if (rx_sym.pos || rx_sym.neg) begin
          zcnt_reg <= 16'h0000;
          los_reg  <= 1'b0;
        end else if (zcnt_reg < 16'(LOS_RUN)) begin
          zcnt_reg <= 16'(zcnt_reg + 16'h0001);
          if (zcnt_reg == 16'(LOS_RUN - 1)) begin
            los_reg <= 1'b1;
          end
        end
      end
    end

    // Lock loss: recovered edges counted over a window of reference edges.
    logic [15:0] refcnt_reg, reccnt_reg;
    logic        lol_reg;

    always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
        refcnt_reg <= 16'h0000;
        reccnt_reg <= 16'h0000;
        lol_reg    <= 1'b0;
      end else if (ce_i) begin
        if (ref_rise && refcnt_reg == 16'(LOCK_WIN - 1)) begin
          refcnt_reg <= 16'h0000;
          reccnt_reg <= {15'h0000, rx_rise};
          lol_reg    <= (reccnt_reg > 16'(LOCK_WIN + LOCK_TOL)) ||
                        (reccnt_reg < 16'(LOCK_WIN - LOCK_TOL));
        end else begin
          if (ref_rise) begin
            refcnt_reg <= 16'(refcnt_reg + 16'h0001);
          end
          if (rx_rise && reccnt_reg != 16'hFFFF) begin
            reccnt_reg <= 16'(reccnt_reg + 16'h0001);
          end
        end
      end
    end

    // Terminal outputs: rails and violation flag moved on the selected recovered clock edge, clock output every cycle.
    logic rx_pos_rail_reg, rx_neg_rail_reg, lcv_reg, rclk_reg, mute;
    assign mute = cfg.mute_on_los && los_reg;

    always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
        rx_pos_rail_reg <= 1'b0;
        rx_neg_rail_reg <= 1'b0;
        lcv_reg  <= 1'b0;
        rclk_reg <= 1'b0;
      end else if (ce_i) begin
        rclk_reg <= rck_q ^ (!host && command_reg_reset_n_pin);
        if (upd) begin
          lcv_reg <= lcv_pend_reg && !mute;
          if (mute) begin
            rx_pos_rail_reg <= 1'b0;
            rx_neg_rail_reg <= 1'b0;
          end else if (single_rail) begin
            rx_pos_rail_reg <= pend_reg.pos || pend_reg.neg;
            rx_neg_rail_reg <= 1'b0;
          end else begin
            rx_pos_rail_reg <= pend_reg.pos;
            rx_neg_rail_reg <= pend_reg.neg;
          end
        end
      end
    end

    assign recovered_clock_out_o[c] = rclk_reg;
    assign rx_pos_rail_o[c]         = rx_pos_rail_reg;
    assign rx_neg_rail_o[c]         = rx_neg_rail_reg;
    assign code_violation_flag_o[c] = lcv_reg;
    assign signal_loss_flag_o[c]    = los_reg;
    assign lock_loss_flag_o[c]      = lol_reg;

    always_comb begin
      status_word[c] = 32'h0000_0000;
      status_word[c][trlcp_pkg::STAT_RATE_LSB +: 2] = cfg.rate;
      status_word[c][trlcp_pkg::STAT_LOS_BIT]  = los_reg;
      status_word[c][trlcp_pkg::STAT_LOL_BIT]  = lol_reg;
      status_word[c][trlcp_pkg::STAT_OFF_BIT]  = line_out_oe_n_o[c];
      status_word[c][trlcp_pkg::STAT_MODE_BIT] = host;
    end
  end

endmodule // trlcp_port

`default_nettype wire

// file: sim/trlcp_sva.sv
/* Concurrent checks on the line codec port pins, bound to the port.
   Assumes one clock domain and pins that change only off clk_i edges. */
`timescale 1ns/1ns
`default_nettype none
module trlcp_sva (
  // Clock, reset and APB
  input wire logic        clk_i, reset_n_i, ce_i, psel_i, penable_i,
  input wire logic        pready_o, pslverr_o,
  input wire logic [11:0] paddr_i,
  // Pins, line and receive side
  input wire logic        host_mode_select_i, command_reg_reset_n_i,
  input wire logic        rx_rail_format_select_i,
  input wire logic [2:0]  transmitter_off_i, equalizer_enable_i, line_clock_i,
  input wire logic [2:0]  line_out_tip_o, line_out_ring_o, line_out_oe_n_o,
  input wire logic [2:0]  equalizer_on_o, recovered_clock_out_o,
  input wire logic [2:0]  rx_pos_rail_o, rx_neg_rail_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  chk_pready_zero_wait: assert property (
    pready_o == (psel_i && penable_i && ce_i)) else $error("bad pready");
  chk_unmapped_err: assert property (
    psel_i && penable_i |-> pslverr_o == !(paddr_i inside
    {12'h000, 12'h004, 12'h008, 12'h010, 12'h014, 12'h018}))
    else $error("bad pslverr");
  chk_off_line_zero: assert property (
    ((line_out_tip_o | line_out_ring_o) & line_out_oe_n_o) == 3'h0)
    else $error("line driven while off");
  chk_one_polarity: assert property (
    (line_out_tip_o & line_out_ring_o) == 3'h0) else $error("both poles");
  chk_rx_rail_excl: assert property (
    (rx_pos_rail_o & rx_neg_rail_o) == 3'h0) else $error("both rails");
  chk_off_pin_float: assert property (
    (transmitter_off_i & $past(transmitter_off_i)
     & $past(transmitter_off_i, 2) & ~line_out_oe_n_o) == 3'h0)
    else $error("off pin not floating");
  chk_eq_pin_hw: assert property (
    !$past(host_mode_select_i, 2) |->
    equalizer_on_o == $past(equalizer_enable_i, 2)) else $error("eq pin");
  chk_clk_out_hw: assert property (
    $rose(line_clock_i[0]) |-> ##4 recovered_clock_out_o[0] ==
    !($past(command_reg_reset_n_i, 3) && !$past(host_mode_select_i, 3)))
    else $error("clock out polarity");
  chk_single_neg_quiet: assert property (
    rx_rail_format_select_i |-> rx_neg_rail_o == 3'h0) else $error("neg rail");
endmodule // trlcp_sva
bind trlcp_port trlcp_sva u_sva (.*);
`default_nettype wire

// file: sim/trlcp_term.sv
/* Terminal model: transmit clock and single-rail data, line looped back.
   Assumes a 32-bit pattern that repeats, least significant bit first. */
`timescale 1ns/1ns
`default_nettype none
module trlcp_term (
  // Pattern and line from the port
  input  wire logic [31:0] pat_i,
  input  wire logic [2:0]  tip_i,
  input  wire logic [2:0]  ring_i,
  // Toward the port
  output logic      [2:0]  clk_o,
  output logic      [2:0]  pos_o,
  output logic      [2:0]  neg_o,
  output logic      [2:0]  ltip_o,
  output logic      [2:0]  lring_o
);
  int k = 0;
  initial begin
    clk_o = 3'h0;
    pos_o = 3'h0;
    #13;
    forever #40 clk_o = ~clk_o;
  end
  // Data moves on the rising edge so the falling-edge sample sees it settled.
  always @(posedge clk_o[0]) begin
    pos_o <= {3{pat_i[k]}};
    k <= (k + 1) % 32;
  end
  assign neg_o = 3'h0;
  assign ltip_o = tip_i;
  assign lring_o = ring_i;
endmodule // trlcp_term
`default_nettype wire

// file: sim/trlcp_port_test.sv
/* Self-checking bench of the line codec port: registers, coded streams
   looped from line out to line in, and hardware pin mode. */
`timescale 1ns/1ns
`default_nettype none
module trlcp_port_test;
  logic        clk_i = 0, reset_n_i = 0, ce_i = 1, psel_i = 0, cap = 0;
  logic        penable_i = 0, pwrite_i = 0, pready_o, pslverr_o;
  logic        host_mode_select_i = 1, command_reg_reset_n_i = 1;
  logic        rx_rail_format_select_i = 1;
  logic [11:0] paddr_i = 12'h000;
  logic [3:0]  pstrb_i = 4'hF;
  logic [31:0] pwdata_i = 32'h0, prdata_o, pat = 32'h0000_8089, rd, er;
  logic [7:0]  v [3];
  logic [2:0]  tx_term_clock_i, tx_pos_rail_i, tx_neg_rail_i, m;
  logic [2:0]  e3_select_i = 0, sts1_select_i = 0, buildout_disable_i = 0;
  logic [2:0]  transmitter_off_i = 0, equalizer_enable_i = 0;
  logic [2:0]  line_out_tip_o, line_out_ring_o, line_out_oe_n_o;
  logic [2:0]  line_in_tip_i, line_in_ring_i, line_clock_i;
  logic [2:0]  lock_reference_clock_i, buildout_on_o, equalizer_on_o;
  logic [2:0]  recovered_clock_out_o, rx_pos_rail_o, rx_neg_rail_o;
  logic [2:0]  code_violation_flag_o, signal_loss_flag_o, lock_loss_flag_o;
  int          err_total = 0, compares = 0, mx, z, nv;
  bit          rq[$], tq[$];
  assign line_clock_i = tx_term_clock_i;
  assign lock_reference_clock_i = tx_term_clock_i;
  trlcp_port #(.LOS_RUN(8), .LOCK_WIN(100), .LOCK_TOL(2)) dut (.*);
  trlcp_term u_term (.pat_i(pat), .tip_i(line_out_tip_o),
    .ring_i(line_out_ring_o), .clk_o(tx_term_clock_i), .pos_o(tx_pos_rail_i),
    .neg_o(tx_neg_rail_i), .ltip_o(line_in_tip_i), .lring_o(line_in_ring_i));
  initial begin
    forever #2 clk_i = ~clk_i;
  end
  task automatic check(input string n, input logic [31:0] s, e);
    compares++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic finish_test();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int t;
    t = 0;
    psel_i <= 1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1;
    do @(posedge clk_i); while (pready_o !== 1'b1 && ++t < 20);
    rd = prdata_o;
    er = 32'(pslverr_o);
    psel_i <= 0;
    penable_i <= 0;
    @(posedge clk_i);
    if (t >= 20) begin
      err_total++;
      finish_test();
    end
  endtask
  // Any rotation of the pattern is accepted: pipeline depth is not checked.
  function automatic bit rot_ok(input bit q[$]);
    bit ok;
    for (int r = 0; r < 32; r++) begin
      ok = 1;
      for (int i = 0; i < 64; i++) ok &= (q[i] == pat[(i + r) % 32]);
      if (ok) return 1;
    end
    return 0;
  endfunction
  always @(posedge tx_term_clock_i[0]) begin
    if (cap) begin
      tq.push_back(line_out_tip_o[0] & !line_out_ring_o[0]);
      z = (line_out_tip_o[0] | line_out_ring_o[0]) ? 0 : z + 1;
      mx = (z > mx) ? z : mx;
    end
  end
  always @(negedge line_clock_i[0]) if (cap) begin
    rq.push_back(rx_pos_rail_o[0] | rx_neg_rail_o[0]);
    nv += code_violation_flag_o[0];
  end
  // Line out is looped to line in, so one stream checks both coders.
  task automatic stream(input logic [7:0] ctl, input int run);
    pat = {16'($urandom), 16'h8089};
    apb(1, 12'h000, {24'h0, ctl});
    repeat (40) @(posedge tx_term_clock_i[0]);
    rq.delete();
    tq.delete();
    mx = 0;
    z = 0;
    nv = 0;
    cap = 1;
    repeat (70) @(posedge tx_term_clock_i[0]);
    cap = 0;
    check("rx data", 32'(rot_ok(rq)), 1);
    if (run < 0)
      check("tip data", 32'(rot_ok(tq)), 1);
    else
      check("zero run", mx, run);
    check("lcv", 32'(nv != 0), 32'(run < 0));
    check("los lol", {signal_loss_flag_o[0] && run >= 0,
      lock_loss_flag_o[0]}, 0);
    @(posedge clk_i);
  endtask
  initial begin
    void'($urandom(32'h6a96));
    repeat (16) @(posedge clk_i);
    reset_n_i <= 1;
    repeat (3) @(posedge clk_i);
    for (int c = 0; c < 3; c++) begin
      v[c] = {6'($urandom), 2'(c)};
      apb(1, 12'(4 * c), {24'h0, v[c]});
    end
    for (int c = 0; c < 3; c++) begin
      apb(0, 12'(4 * c), 0);
      check("ctrl", rd, {24'h0, v[c]});
      apb(0, 12'(16 + 4 * c), 0);
      check("status", {rd[5], rd[1:0]}, {1'b1, 2'(c)});
    end
    apb(0, 12'h020, 0);
    check("unmapped err", er, 1);
    check("unmapped data", rd, 0);
    command_reg_reset_n_i <= 0;
    repeat (4) @(posedge clk_i);
    command_reg_reset_n_i <= 1;
    repeat (3) @(posedge clk_i);
    apb(0, 12'h004, 0);
    check("ctrl reset", rd, 0);
    stream(8'h00, 2);
    stream(8'h0E, 2);
    rx_rail_format_select_i <= 0;
    stream(8'h01, 3);
    stream(8'h10, -1);
    host_mode_select_i <= 0;
    repeat (8) begin
      {sts1_select_i, e3_select_i, buildout_disable_i, transmitter_off_i,
       equalizer_enable_i, command_reg_reset_n_i} <= 16'($urandom);
      repeat (30) @(posedge clk_i);
      m = ~e3_select_i;
      check("oe_n", line_out_oe_n_o, transmitter_off_i);
      check("eq", equalizer_on_o, equalizer_enable_i);
      check("lbo", buildout_on_o & m, ~buildout_disable_i & m);
    end
    finish_test();
  end
  initial begin
    #300000;
    err_total++;
    finish_test();
  end
endmodule // trlcp_port_test
`default_nettype wire
